// ### inc/ccc_pkg.sv
// Shared constants and types of the calendar clock control block
package ccc_pkg;
   // Register bus
   localparam int         ADDR_W = 8;
   localparam int         DATA_W = 32;
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_TIME  = 8'h04;
   localparam logic [7:0] OFF_ISTAT = 8'h08;
   localparam logic [7:0] OFF_IMASK = 8'h0C;
   localparam logic [7:0] OFF_ALARM = 8'h10;
   // Control register fields
   localparam int ON_BIT     = 15;
   localparam int CLKSEL_LSB = 9;
   localparam int OUTSEL_LSB = 7;
   localparam int RUN_BIT    = 6;
   localparam int WREN_BIT   = 3;
   localparam int SYNC_BIT   = 2;
   localparam int HALF_BIT   = 1;
   localparam int OE_BIT     = 0;
   // Time and alarm fields
   localparam int SEC_LSB    = 8;
   localparam int SEC_W      = 7;
   localparam int ALM_EN_BIT = 15;
   // Codes
   localparam logic [1:0] CLKSEL_INTERNAL_LOW_POWER_OSCILLATOR  = 2'h0;
   localparam logic [1:0] CLKSEL_SECONDARY_CRYSTAL_OSCILLATOR  = 2'h1;
   localparam logic [1:0] OUTSEL_ALARM = 2'h0;
   localparam logic [1:0] OUTSEL_SECS  = 2'h1;
   localparam logic [1:0] OUTSEL_RAW   = 2'h2;
   // Interrupt status bits
   localparam int INT_W     = 2;
   localparam int INT_ALARM = 0;
   localparam int INT_SEC   = 1;
   // Oscillator rates and prescaler
   localparam int          SECONDARY_CRYSTAL_OSCILLATOR_HZ   = 32768;
   localparam int          INTERNAL_LOW_POWER_OSCILLATOR_HZ   = 32000;
   localparam int          PRE_W     = 15;
   localparam logic [14:0] SECONDARY_CRYSTAL_OSCILLATOR_LAST = 15'(SECONDARY_CRYSTAL_OSCILLATOR_HZ - 1);
   localparam logic [14:0] INTERNAL_LOW_POWER_OSCILLATOR_LAST = 15'(INTERNAL_LOW_POWER_OSCILLATOR_HZ - 1);
   localparam logic [14:0] SYNC_LEAD = 15'h0020;
   // Clock loss window
   localparam int          SYS_CLK_MHZ = 25;
   localparam int          LOSS_US     = 100;
   localparam int          LOSS_CYC    = LOSS_US * SYS_CLK_MHZ;
   localparam int          IDLE_W      = 12;
   localparam logic [11:0] LOSS_CNT    = 12'(LOSS_CYC);
   // Reset values
   localparam logic [6:0]  SEC_RST = 7'h00;
   localparam logic [15:0] ALM_RST = 16'h0000;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } ccc_bus_s;

   typedef struct packed {
      logic       on;
      logic [1:0] clk_sel;
      logic [1:0] out_sel;
      logic       wren;
      logic       oe;
   } ccc_ctrl_s;

   localparam ccc_ctrl_s CTRL_RST = '{1'b0, 2'h0, 2'h0, 1'b0, 1'b0};
endpackage

// ### hdl/ccc_prescaler.sv
// Oscillator select, second prescaler, status flags and loss detect
`timescale 1ns/10ps
module ccc_prescaler (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       restart_i,
   input  wire logic       run_i,
   input  wire logic [1:0] clk_sel_i,
   input  wire logic       secondary_crystal_oscillator_i,
   input  wire logic       internal_low_power_oscillator_i,
   output logic            raw_o,
   output logic            tick_o,
   output logic            half_o,
   output logic            sync_o,
   output logic            running_o
);
   import ccc_pkg::*;

   logic              prev_ff, nxt_prev, tick_ff, nxt_tick, valid, edge_w;
   logic [PRE_W-1:0]  count_ff, nxt_count, last;
   logic [IDLE_W-1:0] idle_ff, nxt_idle;

   // Source choice, wrap point and counting
   always_comb
   begin
      raw_o = 1'b0;
      last  = SECONDARY_CRYSTAL_OSCILLATOR_LAST;
      valid = 1'b0;
      if (clk_sel_i == CLKSEL_SECONDARY_CRYSTAL_OSCILLATOR)
      begin
         raw_o = secondary_crystal_oscillator_i;
         valid = 1'b1;
      end
      else if (clk_sel_i == CLKSEL_INTERNAL_LOW_POWER_OSCILLATOR)
      begin
         raw_o = internal_low_power_oscillator_i;
         last  = INTERNAL_LOW_POWER_OSCILLATOR_LAST;
         valid = 1'b1;
      end
      edge_w    = raw_o & ~prev_ff;
      nxt_prev  = raw_o;
      nxt_tick  = 1'b0;
      nxt_count = count_ff;
      if (restart_i)
         nxt_count = '0;
      else if (run_i && edge_w)
      begin
         if (count_ff >= last)
         begin
            nxt_count = '0;
            nxt_tick  = 1'b1;
         end
         else
            nxt_count = count_ff + 15'h0001;
      end
      // Idle time saturates so a dead oscillator reads as stopped
      nxt_idle = idle_ff;
      if (edge_w)
         nxt_idle = '0;
      else if (idle_ff != LOSS_CNT)
         nxt_idle = idle_ff + 12'h001;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prev_ff  <= 1'b0;
         tick_ff  <= 1'b0;
         count_ff <= '0;
         idle_ff  <= LOSS_CNT;
      end
      else
      begin
         prev_ff  <= nxt_prev;
         tick_ff  <= nxt_tick;
         count_ff <= nxt_count;
         idle_ff  <= nxt_idle;
      end
   end

   // Flags seen by software
   assign tick_o    = tick_ff;
   assign half_o    = count_ff > (last >> 1);
   assign sync_o    = run_i & (count_ff >= last - SYNC_LEAD);
   assign running_o = valid & (idle_ff != LOSS_CNT);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_secondary_crystal_oscillator_wrap: assert property (
      run_i && !restart_i && clk_sel_i == CLKSEL_SECONDARY_CRYSTAL_OSCILLATOR && edge_w
      && count_ff == SECONDARY_CRYSTAL_OSCILLATOR_LAST |=> tick_o && count_ff == '0)
      else $error("secondary oscillator wrap missed");
   a_internal_low_power_oscillator_wrap: assert property (
      run_i && !restart_i && clk_sel_i == CLKSEL_INTERNAL_LOW_POWER_OSCILLATOR && edge_w
      && count_ff == INTERNAL_LOW_POWER_OSCILLATOR_LAST |=> tick_o && count_ff == '0)
      else $error("internal oscillator wrap missed");
   a_rsvd_stop: assert property (
      clk_sel_i[1] |-> !running_o)
      else $error("reserved source reads as running");
endmodule

// ### hdl/ccc_secs.sv
// Two-digit decimal seconds counter with load
`timescale 1ns/10ps
module ccc_secs (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      clear_i,
   input  wire logic                      load_i,
   input  wire logic [ccc_pkg::SEC_W-1:0] load_val_i,
   input  wire logic                      tick_i,
   output logic      [ccc_pkg::SEC_W-1:0] secs_o
);
   import ccc_pkg::*;

   logic [SEC_W-1:0] secs_ff, nxt_secs;

   // Units wrap at nine, tens at five
   always_comb
   begin
      nxt_secs = secs_ff;
      if (clear_i)
         nxt_secs = SEC_RST;
      else if (load_i)
         nxt_secs = load_val_i;
      else if (tick_i)
      begin
         if (secs_ff[3:0] != 4'h9)
            nxt_secs[3:0] = secs_ff[3:0] + 4'h1;
         else
         begin
            nxt_secs[3:0] = 4'h0;
            if (secs_ff[6:4] == 3'h5)
               nxt_secs[6:4] = 3'h0;
            else
               nxt_secs[6:4] = secs_ff[6:4] + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         secs_ff <= SEC_RST;
      else
         secs_ff <= nxt_secs;
   end

   assign secs_o = secs_ff;
endmodule

// ### hdl/ccc_top.sv
// Calendar clock control: registers, alarm, output pin and interrupt
//
// What this block does
// - Source code 01 picks the crystal oscillator, 00 the internal one.
// - Output code 10 routes the raw clock and 01 the seconds clock.
// - Output code 00 puts a pulse on the pin at each alarm.
// - The pin stays inactive unless the output enable bit is set.
// - The running flag shows whether the chosen clock is toggling.
// - Time writes land only while the write enable bit is set.
// - The write enable bit sets only while the system unlock is open.
// - The module enable changes only while write enable is set.
// - The sync flag is high while a rollover ripple is near.
// - The half second flag is high in the second half of each second.
// - Any write to the time register clears the half second flag.
// - Control returns to reset values only on power-on reset.
`timescale 1ns/10ps
module ccc_top (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       sys_rst_i,
   input  wire logic                       sys_unlock_i,
   input  wire logic                       secondary_crystal_oscillator_i,
   input  wire logic                       internal_low_power_oscillator_i,
   input  wire ccc_pkg::ccc_bus_s          bus_i,
   output logic      [ccc_pkg::DATA_W-1:0] rdata_o,
   output logic                            pin_o,
   output logic                            pin_oe_o,
   output logic                            alarm_o,
   output logic                            irq_o
);
   import ccc_pkg::*;

   // Address match of a strobed access
   function automatic logic hit(input logic stb, input logic [7:0] a,
                                input logic [7:0] off);
      hit = stb && (a == off);
   endfunction

   ccc_ctrl_s         ctrl_ff, nxt_ctrl;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic [INT_W-1:0]  stat_ff, nxt_stat, mask_ff, nxt_mask, evt;
   logic [15:0]       alarm_ff, nxt_alarm;
   logic              pulse_ff, nxt_pulse, pin_ff, nxt_pin;
   logic              tick_d_ff, nxt_tick_d;
   logic              raw, sec_tick, half, sync, running, sel_sig;
   logic              ctl_wr, time_wr, time_ld, alarm_evt;
   logic [SEC_W-1:0]  secs;

   // Decoded writes
   assign ctl_wr  = hit(bus_i.wr, bus_i.addr, OFF_CTRL);
   assign time_wr = hit(bus_i.wr, bus_i.addr, OFF_TIME);
   assign time_ld = time_wr && ctrl_ff.wren;

   // Any time write restarts the prescaler, so the second starts afresh
   ccc_prescaler u_pre (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .restart_i (time_wr || sys_rst_i),
      .run_i     (ctrl_ff.on),
      .clk_sel_i (ctrl_ff.clk_sel),
      .secondary_crystal_oscillator_i    (secondary_crystal_oscillator_i),
      .internal_low_power_oscillator_i    (internal_low_power_oscillator_i),
      .raw_o     (raw),
      .tick_o    (sec_tick),
      .half_o    (half),
      .sync_o    (sync),
      .running_o (running)
   );

   ccc_secs u_secs (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .clear_i    (sys_rst_i),
      .load_i     (time_ld),
      .load_val_i (bus_i.wdata[SEC_LSB +: SEC_W]),
      .tick_i     (sec_tick),
      .secs_o     (secs)
   );

   // Control register, kept through system resets
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      if (ctl_wr)
      begin
         nxt_ctrl.clk_sel = bus_i.wdata[CLKSEL_LSB +: 2];
         nxt_ctrl.out_sel = bus_i.wdata[OUTSEL_LSB +: 2];
         nxt_ctrl.oe      = bus_i.wdata[OE_BIT];
         // Clearing is always allowed; setting needs the unlock
         if (!bus_i.wdata[WREN_BIT])
            nxt_ctrl.wren = 1'b0;
         else if (sys_unlock_i)
            nxt_ctrl.wren = 1'b1;
         // Old write enable value guards the enable bit
         if (ctrl_ff.wren)
            nxt_ctrl.on = bus_i.wdata[ON_BIT];
      end
   end

   // Only power-on reset touches control
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_ff <= CTRL_RST;
      else
         ctrl_ff <= nxt_ctrl;
   end

   // Alarm match is checked the cycle after the seconds step
   assign alarm_evt = tick_d_ff && alarm_ff[ALM_EN_BIT]
                      && (secs == alarm_ff[SEC_LSB +: SEC_W]);
   assign evt = {tick_d_ff, alarm_evt};

   // Alarm setting, interrupt flags, alarm pulse and pin
   always_comb
   begin
      nxt_tick_d = sec_tick;
      nxt_alarm  = alarm_ff;
      nxt_mask   = mask_ff;
      nxt_stat   = stat_ff;
      nxt_pulse  = pulse_ff;
      if (hit(bus_i.wr, bus_i.addr, OFF_ALARM))
      begin
         nxt_alarm = ALM_RST;
         nxt_alarm[ALM_EN_BIT] = bus_i.wdata[ALM_EN_BIT];
         nxt_alarm[SEC_LSB +: SEC_W] = bus_i.wdata[SEC_LSB +: SEC_W];
      end
      if (hit(bus_i.wr, bus_i.addr, OFF_IMASK))
         nxt_mask = bus_i.wdata[INT_W-1:0];
      // Write one to clear, a new event in the same cycle wins
      if (hit(bus_i.wr, bus_i.addr, OFF_ISTAT))
         nxt_stat = stat_ff & ~bus_i.wdata[INT_W-1:0];
      nxt_stat = nxt_stat | evt;
      // Pulse lasts until the half second point
      if (half)
         nxt_pulse = 1'b0;
      if (alarm_evt)
         nxt_pulse = 1'b1;
      if (sys_rst_i)
      begin
         nxt_alarm = ALM_RST;
         nxt_mask  = '0;
         nxt_stat  = '0;
         nxt_pulse = 1'b0;
      end
   end

   // Pin source; reserved code drives low
   always_comb
   begin
      unique case (ctrl_ff.out_sel)
         OUTSEL_ALARM: sel_sig = pulse_ff;
         OUTSEL_SECS:  sel_sig = ~half;
         OUTSEL_RAW:   sel_sig = raw;
         default:      sel_sig = 1'b0;
      endcase
      nxt_pin = ctrl_ff.oe && sel_sig;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tick_d_ff <= 1'b0;
         alarm_ff  <= ALM_RST;
         mask_ff   <= '0;
         stat_ff   <= '0;
         pulse_ff  <= 1'b0;
         pin_ff    <= 1'b0;
      end
      else
      begin
         tick_d_ff <= nxt_tick_d;
         alarm_ff  <= nxt_alarm;
         mask_ff   <= nxt_mask;
         stat_ff   <= nxt_stat;
         pulse_ff  <= nxt_pulse;
         pin_ff    <= nxt_pin;
      end
   end

   // Read data, held for one cycle only
   always_comb
   begin
      // Unused control bits have no storage, so they read as zero
      nxt_rdata = '0;
      if (bus_i.rd)
      begin
         unique case (bus_i.addr)
            OFF_CTRL:
            begin
               nxt_rdata[ON_BIT]            = ctrl_ff.on;
               nxt_rdata[CLKSEL_LSB +: 2]   = ctrl_ff.clk_sel;
               nxt_rdata[OUTSEL_LSB +: 2]   = ctrl_ff.out_sel;
               nxt_rdata[RUN_BIT]           = running;
               nxt_rdata[WREN_BIT]          = ctrl_ff.wren;
               nxt_rdata[SYNC_BIT]          = sync;
               nxt_rdata[HALF_BIT]          = half;
               nxt_rdata[OE_BIT]            = ctrl_ff.oe;
            end
            OFF_TIME:  nxt_rdata[SEC_LSB +: SEC_W] = secs;
            OFF_ISTAT: nxt_rdata[INT_W-1:0] = stat_ff;
            OFF_IMASK: nxt_rdata[INT_W-1:0] = mask_ff;
            OFF_ALARM: nxt_rdata[15:0] = alarm_ff;
            default:   nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_ff <= '0;
      else
         rdata_ff <= nxt_rdata;
   end

   // Outputs
   assign rdata_o  = rdata_ff;
   assign pin_o    = pin_ff;
   assign pin_oe_o = ctrl_ff.oe;
   assign alarm_o  = pulse_ff;
   assign irq_o    = |(stat_ff & mask_ff);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Write lock and enable guard
   a_wren_locked: assert property (
      ctl_wr && bus_i.wdata[WREN_BIT] && !sys_unlock_i && !ctrl_ff.wren
      |=> !ctrl_ff.wren)
      else $error("write enable set while locked");
   a_wren_unlock: assert property (
      ctl_wr && bus_i.wdata[WREN_BIT] && sys_unlock_i |=> ctrl_ff.wren)
      else $error("write enable not set while unlocked");
   a_wren_clear: assert property (
      ctl_wr && !bus_i.wdata[WREN_BIT] |=> !ctrl_ff.wren)
      else $error("write enable not cleared");
   a_on_guard: assert property (
      ctl_wr && !ctrl_ff.wren |=> $stable(ctrl_ff.on))
      else $error("enable bit changed while locked");
   a_time_locked: assert property (
      time_wr && !ctrl_ff.wren && !sec_tick && !sys_rst_i
      |=> $stable(secs))
      else $error("time changed by locked write");
   a_time_load: assert property (
      time_wr && ctrl_ff.wren && !sys_rst_i
      |=> secs == $past(bus_i.wdata[SEC_LSB +: SEC_W]))
      else $error("time write lost");
   a_half_clear: assert property (
      time_wr |=> !half ##1 !half)
      else $error("half second flag not cleared");

   // Pin source and enable
   a_oe_off: assert property (
      !ctrl_ff.oe |=> !pin_o)
      else $error("pin active with output disabled");
   a_raw_route: assert property (
      ctrl_ff.oe && ctrl_ff.out_sel == OUTSEL_RAW |=> pin_o == $past(raw))
      else $error("raw clock not on pin");
   a_secs_route: assert property (
      ctrl_ff.oe && ctrl_ff.out_sel == OUTSEL_SECS
      |=> pin_o == !$past(half))
      else $error("seconds clock not on pin");
   a_alarm_pin: assert property (
      alarm_evt && !sys_rst_i && ctrl_ff.oe
      && ctrl_ff.out_sel == OUTSEL_ALARM && !ctl_wr |=> ##1 pin_o)
      else $error("alarm pulse missing on pin");

   // Status and fields read back
   a_ctrl_fields: assert property (
      hit(bus_i.rd, bus_i.addr, OFF_CTRL)
      |=> rdata_o[WREN_BIT] == $past(ctrl_ff.wren)
          && rdata_o[OE_BIT] == $past(ctrl_ff.oe))
      else $error("control fields read back wrong");
   a_sync_wrap: assert property (
      sec_tick |-> !sync)
      else $error("sync flag high after rollover");
   a_ctrl_status: assert property (
      hit(bus_i.rd, bus_i.addr, OFF_CTRL)
      |=> rdata_o[RUN_BIT] == $past(running)
          && rdata_o[SYNC_BIT] == $past(sync)
          && rdata_o[HALF_BIT] == $past(half))
      else $error("control status bits wrong");
   a_rsvd_zero: assert property (
      hit(bus_i.rd, bus_i.addr, OFF_CTRL) |=> rdata_o[5:4] == 2'h0)
      else $error("unimplemented bits read nonzero");

   // Alarm event beats a clear in the same cycle
   a_stat_set: assert property (
      alarm_evt && !sys_rst_i |=> stat_ff[INT_ALARM])
      else $error("alarm status not set");
   a_pulse_set: assert property (
      alarm_evt && !sys_rst_i |=> alarm_o)
      else $error("alarm pulse not raised");

   // Reset sources
   a_sys_keep: assert property (
      sys_rst_i && !ctl_wr |=> $stable(ctrl_ff))
      else $error("system reset changed control");
   a_sys_clears: assert property (
      sys_rst_i |=> stat_ff == '0 && mask_ff == '0 && !irq_o)
      else $error("system reset left interrupt state");
endmodule

// ### dv/ccc_top_tb.sv
// Self-checking testbench of the calendar clock control block
`timescale 1ns/10ps
module ccc_top_tb;
   import ccc_pkg::*;

   localparam int LIMIT = 110000;

   logic        clk_i;
   logic        rst_i;
   logic        sys_rst_i;
   logic        sys_unlock_i;
   logic        secondary_crystal_oscillator_i = 1'b0;
   logic        internal_low_power_oscillator_i = 1'b0;
   ccc_bus_s    bus;
   logic [31:0] rdata_o;
   logic        pin_o;
   logic        pin_oe_o;
   logic        alarm_o;
   logic        irq_o;
   logic        secondary_crystal_oscillator_run;
   logic        internal_low_power_oscillator_run;
   int          miscompares;
   int          checks;
   int          cycles = 0;
   logic [31:0] d;
   logic        prev;

   ccc_top DUT (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .sys_rst_i    (sys_rst_i),
      .sys_unlock_i (sys_unlock_i),
      .secondary_crystal_oscillator_i       (secondary_crystal_oscillator_i),
      .internal_low_power_oscillator_i       (internal_low_power_oscillator_i),
      .bus_i        (bus),
      .rdata_o      (rdata_o),
      .pin_o        (pin_o),
      .pin_oe_o     (pin_oe_o),
      .alarm_o      (alarm_o),
      .irq_o        (irq_o)
   );

   // 25 MHz system clock
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // Oscillators toggle every cycle, the fastest rate the edge detect sees
   always @(posedge clk_i)
   begin
      if (secondary_crystal_oscillator_run)
         secondary_crystal_oscillator_i <= ~secondary_crystal_oscillator_i;
      if (internal_low_power_oscillator_run)
         internal_low_power_oscillator_i <= ~internal_low_power_oscillator_i;
   end

   // Hang guard: a full second of prescaler takes about 65k cycles
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      if (miscompares == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic clks(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // One-cycle write strobe beside address and data
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      bus.wr    <= 1'b1;
      bus.addr  <= a;
      bus.wdata <= v;
      @(posedge clk_i);
      bus.wr    <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      bus.rd   <= 1'b1;
      bus.addr <= a;
      @(posedge clk_i);
      bus.rd   <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
   endtask

   // Main sequence
   initial
   begin
      rst_i        = 1'b1;
      sys_rst_i    = 1'b0;
      sys_unlock_i = 1'b0;
      bus          = '0;
      secondary_crystal_oscillator_run     = 1'b0;
      internal_low_power_oscillator_run     = 1'b0;
      miscompares  = 0;
      checks       = 0;
      clks(10);
      rst_i <= 1'b0;
      rd(OFF_CTRL, d);
      chk("ctrl_reset", d, 32'h0000_0000);
      // Write enable refused while the system unlock is closed
      wr(OFF_CTRL, 32'h0000_0009);
      rd(OFF_CTRL, d);
      chk("wren_locked", d, 32'h0000_0001);
      // Enable bit refused while the old write enable is clear
      @(posedge clk_i);
      sys_unlock_i <= 1'b1;
      wr(OFF_CTRL, 32'h0000_8339);
      rd(OFF_CTRL, d);
      chk("on_refused", d, 32'h0000_0309);
      secondary_crystal_oscillator_run <= 1'b1;
      wr(OFF_CTRL, 32'h0000_8339);
      clks(20);
      rd(OFF_CTRL, d);
      chk("ctrl_on", d, 32'h0000_8349);
      // Raw clock on the pin toggles with the oscillator
      @(negedge clk_i);
      prev = pin_o;
      repeat (4)
      begin
         @(negedge clk_i);
         chk("pin_raw", {31'h0, pin_o}, {31'h0, ~prev});
         chk("pin_oe", {31'h0, pin_oe_o}, 32'h1);
         prev = pin_o;
      end
      // Output disabled keeps the pin quiet
      wr(OFF_CTRL, 32'h0000_8348);
      clks(2);
      repeat (4)
      begin
         @(negedge clk_i);
         chk("pin_off", {30'h0, pin_oe_o, pin_o}, 32'h0);
      end
      // Internal oscillator idle and reserved codes give no clock
      // Only the idle oscillator needs the full loss window to pass
      for (int i = 0; i < 3; i++)
      begin
         wr(OFF_CTRL, 32'h0000_8008 | (32'(i == 0 ? 0 : i + 1) << 9));
         clks(i == 0 ? 2600 : 20);
         rd(OFF_CTRL, d);
         chk("run_none", {31'h0, d[RUN_BIT]}, 32'h0);
      end
      internal_low_power_oscillator_run <= 1'b1;
      wr(OFF_CTRL, 32'h0000_8008);
      clks(20);
      rd(OFF_CTRL, d);
      chk("run_internal_low_power_oscillator", {31'h0, d[RUN_BIT]}, 32'h1);
      internal_low_power_oscillator_run <= 1'b0;
      wr(OFF_CTRL, 32'h0000_8208);
      clks(20);
      rd(OFF_CTRL, d);
      chk("run_secondary_crystal_oscillator", {31'h0, d[RUN_BIT]}, 32'h1);
      // Other reset sources leave the control register alone
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(OFF_CTRL, d);
      chk("ctrl_kept", d & 32'h0000_FF89, 32'h0000_8208);
      // Alarm at second 26, seconds clock on the pin, start at 25
      wr(OFF_IMASK, 32'h0000_0001);
      wr(OFF_ALARM, 32'h0000_A600);
      wr(OFF_CTRL, 32'h0000_8289);
      wr(OFF_TIME, 32'h0000_2500);
      clks(4);
      rd(OFF_TIME, d);
      chk("time_load", d, 32'h0000_2500);
      rd(OFF_CTRL, d);
      chk("half_low", {31'h0, d[HALF_BIT]}, 32'h0);
      chk("pin_secs_hi", {31'h0, pin_o}, 32'h1);
      clks(33000);
      rd(OFF_CTRL, d);
      chk("half_high", {31'h0, d[HALF_BIT]}, 32'h1);
      chk("pin_secs_lo", {31'h0, pin_o}, 32'h0);
      wr(OFF_TIME, 32'h0000_2500);
      rd(OFF_CTRL, d);
      chk("half_clear", {31'h0, d[HALF_BIT]}, 32'h0);
      wr(OFF_CTRL, 32'h0000_8209);
      // Wait for the ripple warning ahead of the rollover
      d = '0;
      for (int n = 0; n < 34000 && d[SYNC_BIT] !== 1'b1; n++)
         rd(OFF_CTRL, d);
      chk("sync_set", {31'h0, d[SYNC_BIT]}, 32'h1);
      chk("half_late", {31'h0, d[HALF_BIT]}, 32'h1);
      rd(OFF_TIME, d);
      chk("time_before", d, 32'h0000_2500);
      rd(OFF_TIME, d);
      chk("time_twice", d, 32'h0000_2500);
      // Time data in d must not end the wait before a fresh flag read
      d[SYNC_BIT] = 1'b1;
      for (int n = 0; n < 100 && d[SYNC_BIT] !== 1'b0; n++)
         rd(OFF_CTRL, d);
      chk("sync_clear", {31'h0, d[SYNC_BIT]}, 32'h0);
      clks(8);
      @(negedge clk_i);
      chk("alarm", {31'h0, alarm_o}, 32'h1);
      chk("pin_alarm", {31'h0, pin_o}, 32'h1);
      chk("irq_set", {31'h0, irq_o}, 32'h1);
      rd(OFF_TIME, d);
      chk("time_tick", d, 32'h0000_2600);
      rd(OFF_CTRL, d);
      chk("half_new", {31'h0, d[HALF_BIT]}, 32'h0);
      // Clearing the alarm leaves only the masked second event
      wr(OFF_ISTAT, 32'h0000_0001);
      clks(2);
      @(negedge clk_i);
      chk("irq_clear", {31'h0, irq_o}, 32'h0);
      rd(OFF_ISTAT, d);
      chk("istat", d, 32'h0000_0002);
      // Locked time register ignores writes
      wr(OFF_CTRL, 32'h0000_8200);
      wr(OFF_TIME, 32'h0000_3300);
      rd(OFF_TIME, d);
      chk("time_locked", d, 32'h0000_2600);
      wr(8'h14, 32'hFFFF_FFFF);
      rd(8'h14, d);
      chk("unmapped", d, 32'h0000_0000);
      // Power-on reset clears the control register
      secondary_crystal_oscillator_run <= 1'b0;
      @(posedge clk_i);
      rst_i <= 1'b1;
      clks(2);
      rst_i <= 1'b0;
      rd(OFF_CTRL, d);
      chk("ctrl_por", d, 32'h0000_0000);
      chk("oe_por", {31'h0, pin_oe_o}, 32'h0);
      conclude();
   end
endmodule
